// file: logic/rss_sequencer.sv
// reset and start-up sequencer with watchdog, status flags and register file
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps

module rss_sequencer (
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  input  wire logic                  extResetLowPin,
  input  wire logic [7:0]            portAWakePin,
  input  wire logic [7:0]            portAWakeEnable,
  input  wire logic                  wdtEnable,
  input  wire logic                  clrWdtTwice,
  input  rss_pkg::rss_core_cmd_t     coreCmd,
  input  rss_pkg::rss_apb_req_t      apbReq,
  output rss_pkg::rss_apb_rsp_t      apbRsp,
  output rss_pkg::rss_ctrl_t         ctrl
);

  // ****************************************
  // state
  // ****************************************
  rss_pkg::rss_state_t  state;            // sequencer state
  rss_pkg::rss_state_t  next_state;       // sequencer next state
  logic [rss_pkg::CNT_W-1:0] delayCnt;    // start-up / option delay counter
  logic                 needOpt;          // option delay follows start-up
  logic                 next_needOpt;     // its next value
  logic [7:0]           regs [16];        // register file by index
  logic                 toFlag;           // watchdog time-out flag
  logic                 pdFlag;           // power-down flag

  // synchronisers
  logic                 pinSync1;         // first stage, read only by second
  logic                 pinSync2;         // stable reset pin level
  logic [7:0]           paSync1;          // first stage of wake pins
  logic [7:0]           paSync2;          // stable wake pin levels
  logic [7:0]           paLast;           // previous levels for edge detect

  // watchdog
  logic [1:0]           wdtDiv;           // instruction clock divider
  logic                 wdtTick;          // instruction clock enable
  logic [rss_pkg::WDT_W-1:0] wdtCnt;      // counter with prescaler
  logic [rss_pkg::WDT_W-1:0] wdtMask;     // stages used by the ratio
  logic                 got1;             // first of two clear instructions seen
  logic                 got2;             // second of two clear instructions seen
  logic                 clearWdtEff;      // clear-watchdog instruction takes effect

  // events
  logic                 pinLow;           // reset pin held low
  logic                 paFall;           // enabled wake pin fell
  logic                 wdtExpire;        // watchdog overflow this cycle
  logic                 fullNow;          // full chip reset this cycle
  logic                 wakeNow;          // non-reset halt exit this cycle

  // bus
  logic [3:0]           rdIdx;            // addressed register
  logic                 wrEn;             // register write this cycle
  // core controls, kept apart so the output struct has one driver
  logic                 holdQ;            // core held out of run
  logic                 chipQ;            // full chip reset applied
  logic                 pcSpQ;            // pc and sp cleared

  // ****************************************
  // decoding
  // ****************************************
  // word-aligned and inside the sixteen-word map
  function automatic logic addrOk(input logic [7:0] a);
    addrOk = (a[1:0] == 2'h0) && (a[7:6] == 2'h0);
  endfunction

  // ****************************************
  // synchronisers
  // ****************************************
  // pin reset idles high so the stages start high
  // two-flop pin sync
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      pinSync1 <= 1'b1;
      pinSync2 <= 1'b1;
    end
    else
    begin
      pinSync1 <= extResetLowPin;
      pinSync2 <= pinSync1;
    end
  end

  // wake pins, edge detect looks only at the second stage
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      paSync1 <= 8'hff;
      paSync2 <= 8'hff;
      paLast  <= 8'hff;
    end
    else
    begin
      paSync1 <= portAWakePin;
      paSync2 <= paSync1;
      paLast  <= paSync2;
    end
  end

  assign pinLow = ~pinSync2;
  // falling edge on enabled wake pin
  assign paFall = |(portAWakeEnable & paLast & ~paSync2);

  // ****************************************
  // watchdog
  // ****************************************
  // divider for the instruction clock enable
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      wdtDiv  <= 2'h0;
      wdtTick <= 1'b0;
    end
    else
    begin
      wdtDiv  <= wdtDiv + 2'h1;
      wdtTick <= (wdtDiv == rss_pkg::WDT_DIV_LAST);
    end
  end

  // two-instruction clear, both halves of the pair must be seen
  always_ff @(posedge ref_clk)
  begin
    if (reset || clearWdtEff)
    begin
      got1 <= 1'b0;
      got2 <= 1'b0;
    end
    else
    begin
      got1 <= got1 | coreCmd.clearWdt1;
      got2 <= got2 | coreCmd.clearWdt2;
    end
  end

  // pair or single instruction, chosen by the option
  assign clearWdtEff = clrWdtTwice ?
    ((got1 | coreCmd.clearWdt1) & (got2 | coreCmd.clearWdt2)) : coreCmd.clearWdt;

  // ratio 1:1 uses 8 stages, each ratio step adds one more
  assign wdtMask = {rss_pkg::WDT_W{1'b1}} >> (3'h7 - regs[rss_pkg::IDX_WATCHDOG_SELECT][2:0]);

  // overflow when every used stage is one at a tick
  assign wdtExpire = wdtEnable && wdtTick && ((wdtCnt & wdtMask) == wdtMask)
                     && !pinLow && !clearWdtEff && !coreCmd.halt;

  // counter; it keeps running in halt so it can wake the core
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      wdtCnt <= '0;
    // pin, instruction and halt clear it
    else if (pinLow || clearWdtEff || coreCmd.halt)
      wdtCnt <= '0;
    // chip reset clears, counting restarts after
    else if (fullNow || wdtExpire)
      wdtCnt <= '0;
    else if (wdtEnable && wdtTick)
      wdtCnt <= wdtCnt + 1'b1;
  end

  // ****************************************
  // sequencer
  // ****************************************
  // pin low anywhere or watchdog in run
  assign fullNow = pinLow || ((state == rss_pkg::ST_RUN) && wdtExpire);
  // irq or wake pin leaves halt without reset
  assign wakeNow = coreCmd.wakeIrq || paFall;

  // next state
  always_comb
  begin
    next_state   = state;
    next_needOpt = needOpt;
    if (pinLow)
      // hold while the pin stays low
      next_state = rss_pkg::ST_PIN;
    else
    begin
      unique case (state)
        rss_pkg::ST_PIN:
        begin
          next_state   = rss_pkg::ST_SST;
          next_needOpt = 1'b1;
        end
        rss_pkg::ST_RUN:
        begin
          if (wdtExpire)
          begin
            next_state   = rss_pkg::ST_SST;
            next_needOpt = 1'b1;
          end
          else if (coreCmd.halt)
            next_state = rss_pkg::ST_HALT;
        end
        rss_pkg::ST_HALT:
        begin
          // any exit starts the start-up delay
          if (wdtExpire || wakeNow)
          begin
            next_state   = rss_pkg::ST_SST;
            next_needOpt = 1'b0;
          end
        end
        rss_pkg::ST_SST:
        begin
          if (delayCnt == rss_pkg::CNT_W'(rss_pkg::SST_CYCLES - 1))
            next_state = needOpt ? rss_pkg::ST_OPT : rss_pkg::ST_RUN;
        end
        rss_pkg::ST_OPT:
        begin
          if (delayCnt == rss_pkg::CNT_W'(rss_pkg::OPT_LOAD_CYCLES - 1))
            next_state = rss_pkg::ST_RUN;
        end
        default:
          next_state = rss_pkg::ST_SST;
      endcase
    end
  end

  // state and the delay counter, restarted on every state change
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      // power-up runs start-up then option delay
      state    <= rss_pkg::ST_SST;
      needOpt  <= 1'b1;
      delayCnt <= '0;
    end
    else
    begin
      state    <= next_state;
      needOpt  <= next_needOpt;
      delayCnt <= (next_state != state) ? '0 : delayCnt + 1'b1;
    end
  end

  // ****************************************
  // status flags
  // ****************************************
  // reset cause encoding
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      // power-up gives 0,0
      toFlag <= 1'b0;
      pdFlag <= 1'b0;
    end
    else if (pinLow && state == rss_pkg::ST_HALT)
    begin
      // pin wake from halt gives 0,1
      toFlag <= 1'b0;
      pdFlag <= 1'b1;
    end
    else if (wdtExpire && state == rss_pkg::ST_HALT)
    begin
      // watchdog wake gives 1,1
      toFlag <= 1'b1;
      pdFlag <= 1'b1;
    end
    else if (wdtExpire)
      // time-out sets the flag, power-down unchanged
      toFlag <= 1'b1;
    else if (state == rss_pkg::ST_RUN && !pinLow)
    begin
      // halt sets, wins over a same-cycle clear
      if (coreCmd.halt)
      begin
        pdFlag <= 1'b1;
        toFlag <= 1'b0;
      end
      else if (clearWdtEff)
        pdFlag <= 1'b0;
    end
  end

  // ****************************************
  // register file
  // ****************************************
  assign rdIdx = apbReq.paddr[5:2];
  assign wrEn  = apbReq.psel && apbReq.penable && apbRsp.pready
                 && apbReq.pwrite && addrOk(apbReq.paddr);

  // writes are dropped while a chip reset is held
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      // power-on defines even the kept registers, as zero
      for (int i = 0; i < 16; i++)
        regs[i] <= rss_pkg::RST_VAL[i];
    end
    else if (fullNow)
    begin
      for (int i = 0; i < 16; i++)
        if (!rss_pkg::KEEP_ON_RESET[i])
          regs[i] <= rss_pkg::RST_VAL[i];
    end
    // warm reset leaves the file untouched
    else if (wrEn)
      regs[rdIdx] <= (apbReq.pwdata[7:0] & rss_pkg::WR_MASK[rdIdx])
                     | (regs[rdIdx] & ~rss_pkg::WR_MASK[rdIdx]);
  end

  // ****************************************
  // apb slave
  // ****************************************
  // answer is ready in the first access cycle, so no wait states
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      apbRsp <= '0;
    end
    else
    begin
      apbRsp.pready  <= apbReq.psel && !apbReq.penable;
      apbRsp.pslverr <= apbReq.psel && !apbReq.penable && !addrOk(apbReq.paddr);
      if (apbReq.psel && !apbReq.penable)
      begin
        // capture read data in the setup cycle
        if (!addrOk(apbReq.paddr))
          apbRsp.prdata <= '0;
        else if (rdIdx == rss_pkg::IDX_STATUS)
          apbRsp.prdata <= {26'h0, toFlag, pdFlag, regs[rdIdx][3:0]};
        else if (rdIdx == rss_pkg::IDX_SEQ)
          apbRsp.prdata <= {27'h0, state};
        else
          apbRsp.prdata <= {24'h0, regs[rdIdx] & rss_pkg::RD_MASK[rdIdx]};
      end
    end
  end

  // ****************************************
  // core controls
  // ****************************************
  // reset strobes, held for as long as the cause stands
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      holdQ <= 1'b1;
      chipQ <= 1'b1;
      pcSpQ <= 1'b1;
    end
    else
    begin
      holdQ <= (next_state != rss_pkg::ST_RUN);
      chipQ <= fullNow;
      // warm reset clears pc and sp only
      pcSpQ <= fullNow || (wdtExpire && state == rss_pkg::ST_HALT);
    end
  end

  // register views, each bit already a flop of the file
  // ports input, timer off, interrupts off after reset
  // unused bits can never be written, so no mask is needed here
  assign ctrl = '{coreHold: holdQ, chipReset: chipQ, pcSpClear: pcSpQ,
    interruptControl: regs[rss_pkg::IDX_INTERRUPT_CONTROL], timerControl: regs[rss_pkg::IDX_TIMER_CONTROL],
    watchdogSelect: regs[rss_pkg::IDX_WATCHDOG_SELECT], portAData: regs[rss_pkg::IDX_PA],
    portADirection: regs[rss_pkg::IDX_PAC], portBData: regs[rss_pkg::IDX_PB][2:0],
    portBDirection: regs[rss_pkg::IDX_PBC][2:0], portCData: regs[rss_pkg::IDX_PC][1:0],
    portCDirection: regs[rss_pkg::IDX_PCC][1:0]};

endmodule

// file: logic/rss_pkg.sv
// shared constants, register map and carrier types of the reset sequencer
package rss_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int SST_CYCLES      = 1024;  // start-up delay in system clocks
  localparam int OPT_LOAD_CYCLES = 16;    // option load delay in system clocks
  localparam int CNT_W           = 11;    // wide enough for both delays
  localparam int WDT_W           = 15;    // 8 stages plus 7 prescaler stages
  localparam logic [1:0] WDT_DIV_LAST = 2'h3;  // instruction clock is system / 4

  // ****************************************
  // register indices, byte address is four times the index
  // ****************************************
  localparam logic [3:0] IDX_MP     = 4'h0;
  localparam logic [3:0] IDX_ACC    = 4'h1;
  localparam logic [3:0] IDX_TABLE_POINTER   = 4'h2;
  localparam logic [3:0] IDX_TABLE_HIGH_BYTE   = 4'h3;
  localparam logic [3:0] IDX_STATUS = 4'h4;
  localparam logic [3:0] IDX_INTERRUPT_CONTROL   = 4'h5;
  localparam logic [3:0] IDX_WATCHDOG_SELECT   = 4'h6;
  localparam logic [3:0] IDX_PA     = 4'h7;
  localparam logic [3:0] IDX_PAC    = 4'h8;
  localparam logic [3:0] IDX_PB     = 4'h9;
  localparam logic [3:0] IDX_PBC    = 4'ha;
  localparam logic [3:0] IDX_PC     = 4'hb;
  localparam logic [3:0] IDX_PCC    = 4'hc;
  localparam logic [3:0] IDX_TMR    = 4'hd;
  localparam logic [3:0] IDX_TIMER_CONTROL   = 4'he;
  localparam logic [3:0] IDX_SEQ    = 4'hf;

  // values after a full reset, by index
  localparam logic [7:0] RST_VAL [16] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h07, 8'hff, 8'hff, 8'h07, 8'h07, 8'h03, 8'h03, 8'h00, 8'h08, 8'h00};
  // registers that keep their value on a full reset other than power-on
  localparam logic [15:0] KEEP_ON_RESET = 16'h001f;
  // implemented bits, others read zero
  localparam logic [7:0] RD_MASK [16] = '{8'h7f, 8'hff, 8'hff, 8'h3f, 8'h3f, 8'h37,
    8'hff, 8'hff, 8'hff, 8'h07, 8'h07, 8'h03, 8'h03, 8'hff, 8'hdf, 8'h1f};
  // bits that software may write
  localparam logic [7:0] WR_MASK [16] = '{8'h7f, 8'hff, 8'hff, 8'h00, 8'h0f, 8'h37,
    8'hff, 8'hff, 8'hff, 8'h07, 8'h07, 8'h03, 8'h03, 8'hff, 8'hdf, 8'h00};
  localparam int FLAG_TO  = 5;  // status bit of the time-out flag
  localparam int FLAG_PDF = 4;  // status bit of the power-down flag

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [4:0] {
    ST_RUN  = 5'h01,
    ST_HALT = 5'h02,
    ST_PIN  = 5'h04,
    ST_SST  = 5'h08,
    ST_OPT  = 5'h10
  } rss_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } rss_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } rss_apb_rsp_t;

  // instruction events from the core, one-cycle pulses
  typedef struct packed {
    logic halt;
    logic clearWdt;
    logic clearWdt1;
    logic clearWdt2;
    logic wakeIrq;
  } rss_core_cmd_t;

  // controls handed to the core and peripherals
  typedef struct packed {
    logic       coreHold;
    logic       chipReset;
    logic       pcSpClear;
    logic [7:0] interruptControl;
    logic [7:0] timerControl;
    logic [7:0] watchdogSelect;
    logic [7:0] portAData;
    logic [7:0] portADirection;
    logic [2:0] portBData;
    logic [2:0] portBDirection;
    logic [1:0] portCData;
    logic [1:0] portCDirection;
  } rss_ctrl_t;

endpackage

// file: bench/rss_pin_model.sv
// model of the external reset circuit driving the active low reset pin
`timescale 1ns/100ps
module rss_pin_model (
  input  wire logic        ref_clk,
  input  wire logic        powerOn,
  input  wire logic        pulseReq,
  input  wire logic [15:0] lowCycles,
  output logic             extResetLowPin
);
  logic [15:0] lowCnt;  // cycles the pin still stays low

  // ****************************************
  // pin low timing
  // ****************************************
  // pin held low until oscillator runs
  always_ff @(posedge ref_clk)
  begin
    if (powerOn || pulseReq)
      lowCnt <= lowCycles;
    else if (lowCnt != 16'h0)
      lowCnt <= lowCnt - 16'h1;
  end

  // low while power comes up, so no glitch before the count loads
  assign extResetLowPin = (lowCnt == 16'h0) && !powerOn;
endmodule

// file: bench/rss_seq_sva.sv
// assertion checker bound to the reset sequencer ports
`timescale 1ns/100ps
module rss_seq_sva (
  input wire logic              ref_clk,
  input wire logic              reset,
  input wire logic              extResetLowPin,
  input wire logic [7:0]        portAWakePin,
  input wire logic [7:0]        portAWakeEnable,
  input wire logic              wdtEnable,
  input wire logic              clrWdtTwice,
  input rss_pkg::rss_core_cmd_t coreCmd,
  input rss_pkg::rss_apb_req_t  apbReq,
  input rss_pkg::rss_apb_rsp_t  apbRsp,
  input rss_pkg::rss_ctrl_t     ctrl
);
  logic [10:0] holdCnt;  // cycles the core has been held
  logic        apbWr;    // a write landed at the last edge
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  // saturating so a long pin reset cannot wrap
  always_ff @(posedge ref_clk)
  begin
    if (reset || !ctrl.coreHold)
      holdCnt <= 11'h0;
    else if (holdCnt != 11'h7ff)
      holdCnt <= holdCnt + 11'h1;
  end

  // writes may legally change registers, so exclude them
  always_ff @(posedge ref_clk)
  begin
    apbWr <= apbReq.psel && apbReq.penable && apbReq.pwrite && apbRsp.pready;
  end

  // ****************************************
  // assertions
  // ****************************************
  hold_min_a: assert property ($fell(ctrl.coreHold) |-> holdCnt >= 11'h400)
    else $error("core released before start-up delay");
  chip_hold_a: assert property (ctrl.chipReset |-> ctrl.coreHold && ctrl.pcSpClear)
    else $error("chip reset without hold or pc clear");
  reg_init_a: assert property (
    $fell(ctrl.chipReset) && !apbWr |-> ctrl.watchdogSelect == 8'h07
    && ctrl.timerControl == 8'h08 && ctrl.portADirection == 8'hff
    && ctrl.interruptControl == 8'h00 && ctrl.portBData == 3'h7 && ctrl.portCDirection == 2'h3)
    else $error("register not at initial value after chip reset");
  warm_keep_a: assert property (
    ctrl.pcSpClear && !ctrl.chipReset && !apbWr |-> $stable(ctrl.portAData)
    && $stable(ctrl.watchdogSelect) && $stable(ctrl.interruptControl))
    else $error("warm reset disturbed a register");
  warm_hold_a: assert property (ctrl.pcSpClear |-> ctrl.coreHold)
    else $error("pc clear without core hold");
  pin_hold_a: assert property ((!extResetLowPin && !reset) [*4] |-> ctrl.chipReset)
    else $error("pin held low but no chip reset");
  halt_enter_a: assert property (coreCmd.halt && !ctrl.coreHold |=> ctrl.coreHold)
    else $error("halt did not stop the core");
  apb_ready_a: assert property (
    apbReq.psel && !apbReq.penable |=> apbRsp.pready ##1 !apbRsp.pready)
    else $error("ready not a single access cycle");
  apb_err_a: assert property (
    apbReq.psel && !apbReq.penable && apbReq.paddr[7:6] != 2'h0
    |=> apbRsp.pslverr && apbRsp.prdata == 32'h0)
    else $error("unmapped access not refused");

  cover property ($fell(ctrl.coreHold));
  cover property (ctrl.pcSpClear && !ctrl.chipReset);
  cover property (apbRsp.pslverr);
endmodule

bind rss_sequencer rss_seq_sva chk_u (.ref_clk, .reset, .extResetLowPin, .portAWakePin,
  .portAWakeEnable, .wdtEnable, .clrWdtTwice, .coreCmd, .apbReq, .apbRsp, .ctrl);

// file: bench/tb_top.sv
// self-checking bench of the reset sequencer
`timescale 1ns/100ps
module tb_top;
  localparam int PIN = 5;   // pin reset request
  localparam int HALT = 4;  // halt pulse
  localparam int CLR = 3;   // single clear-watchdog
  localparam int CLR1 = 2;  // first of the clear pair
  localparam int CLR2 = 1;  // second of the clear pair
  localparam int IRQ = 0;   // interrupt wake
  logic                   ref_clk;
  logic                   reset;
  logic                   pulseReq;
  logic                   extResetLowPin;
  logic                   wdtEnable;
  logic                   clrWdtTwice;
  logic                   lastErr;  // error flag of the last transfer
  logic [7:0]             portAWakePin;
  logic [7:0]             portAWakeEnable;
  logic [7:0]             rdVal;
  rss_pkg::rss_core_cmd_t coreCmd;
  rss_pkg::rss_apb_req_t  apbReq;
  rss_pkg::rss_apb_rsp_t  apbRsp;
  rss_pkg::rss_ctrl_t     ctrl;
  int                     failures = 0;
  int                     total_checks = 0;
  int                     cycles = 0;
  int                     n;

  // device under test
  rss_sequencer dut_u (.ref_clk, .reset, .extResetLowPin, .portAWakePin, .portAWakeEnable,
    .wdtEnable, .clrWdtTwice, .coreCmd, .apbReq, .apbRsp, .ctrl);
  rss_pin_model pin_u (.ref_clk, .powerOn(reset), .pulseReq, .lowCycles(16'h0028),
    .extResetLowPin);

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // hang guard
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      end_of_test();
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic end_of_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_range(input string what, input int lo, input int hi, input int got);
    total_checks++;
    if (got < lo || got > hi)
    begin
      failures++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  // apb transfer held until ready is sampled high
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd);
    @(posedge ref_clk);
    apbReq <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:{idx, 2'h0}, pwdata:{24'h0, wd}};
    @(posedge ref_clk);
    apbReq.penable <= 1'b1;
    // only ready high or the hang guard ends this wait
    do @(posedge ref_clk); while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata[7:0];
    lastErr = apbRsp.pslverr;
    apbReq <= '0;
  endtask

  task automatic chk_reg(input string what, input logic [5:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h0, rdVal);
    cmp8(what, exp, rdVal);
  endtask

  // one-cycle pulse on a core event or the pin request
  task automatic pulse(input int which);
    @(posedge ref_clk);
    {pulseReq, coreCmd} <= 6'h01 << which;
    @(posedge ref_clk);
    {pulseReq, coreCmd} <= 6'h00;
  endtask

  // wait for the hold to start, then count it
  task automatic wait_run(output int cnt);
    cnt = 0;
    do @(posedge ref_clk); while (ctrl.coreHold !== 1'b1 && ++cnt < 10);
    cnt = 0;
    do @(posedge ref_clk); while (ctrl.coreHold !== 1'b0 && ++cnt < 3000);
  endtask

  task automatic wait_ctl(input bit warm, output int cnt);
    cnt = 0;
    do @(posedge ref_clk); while ((warm ? ctrl.pcSpClear : ctrl.chipReset) !== 1'b1
                                  && ++cnt < 2000);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_power();
    logic [7:0] expv [9] = '{8'h00, 8'h07, 8'hff, 8'hff, 8'h07, 8'h07, 8'h03, 8'h03, 8'h08};
    wait_run(n);
    chk_range("power-up hold", 1070, 1100, n);
    chk_reg("flags", 6'h4, 8'h00);
    for (int i = 0; i < 9; i++)
      chk_reg("reset value", (i < 8) ? 6'(5 + i) : 6'he, expv[i]);
    cmp8("port a dir", 8'hff, ctrl.portADirection);
    apb(1'b1, 6'h4, 8'h30, rdVal);
    chk_reg("flags read-only", 6'h4, 8'h00);
    apb(1'b0, 6'h10, 8'h0, rdVal);
    cmp8("unmapped error", 8'h01, {7'h0, lastErr});
  endtask

  task automatic t_halt_wake();
    apb(1'b1, 6'h1, 8'h5a, rdVal);
    portAWakeEnable <= 8'h01;
    pulse(HALT);
    pulse(IRQ);
    wait_run(n);
    chk_range("irq wake hold", 1020, 1040, n);
    chk_reg("flags", 6'h4, 8'h10);
    pulse(HALT);
    portAWakePin <= 8'hfe;
    wait_run(n);
    chk_range("pin wake hold", 1020, 1045, n);
    portAWakePin <= 8'hff;
  endtask

  task automatic t_pin_run();
    apb(1'b1, 6'h7, 8'h00, rdVal);
    pulse(PIN);
    wait_run(n);
    chk_range("pin reset hold", 1070, 1100, n);
    chk_reg("flags", 6'h4, 8'h10);
    chk_reg("acc kept", 6'h1, 8'h5a);
    chk_reg("port a", 6'h7, 8'hff);
  endtask

  task automatic t_pin_halt();
    pulse(CLR);
    chk_reg("flags", 6'h4, 8'h00);
    pulse(HALT);
    pulse(PIN);
    wait_run(n);
    chk_reg("flags", 6'h4, 8'h10);
  endtask

  task automatic t_wdt_run();
    pulse(CLR);
    apb(1'b1, 6'h6, 8'h00, rdVal);
    apb(1'b1, 6'h1, 8'h3c, rdVal);
    wdtEnable <= 1'b1;
    wait_ctl(1'b0, n);
    chk_range("watchdog period", 1000, 1040, n);
    wdtEnable <= 1'b0;
    wait_run(n);
    chk_reg("flags", 6'h4, 8'h20);
    chk_reg("wdt select", 6'h6, 8'h07);
    chk_reg("acc kept", 6'h1, 8'h3c);
  endtask

  task automatic t_wdt_halt();
    apb(1'b1, 6'h6, 8'h00, rdVal);
    apb(1'b1, 6'h7, 8'h55, rdVal);
    wdtEnable <= 1'b1;
    pulse(HALT);
    wait_ctl(1'b1, n);
    // stop the watchdog so it cannot expire again as the delay ends
    wdtEnable <= 1'b0;
    cmp8("warm no chip reset", 8'h00, {7'h0, ctrl.chipReset});
    wait_run(n);
    chk_range("warm hold", 1018, 1036, n);
    chk_reg("flags", 6'h4, 8'h30);
    chk_reg("port a kept", 6'h7, 8'h55);
    chk_reg("wdt select kept", 6'h6, 8'h00);
  endtask

  // pair option: single form and half pair leave power-down set
  task automatic t_wdt_pair();
    clrWdtTwice <= 1'b1;
    pulse(CLR);
    chk_reg("single clear ignored", 6'h4, 8'h30);
    pulse(CLR1);
    chk_reg("half pair ignored", 6'h4, 8'h30);
    pulse(CLR2);
    chk_reg("pair clears pd", 6'h4, 8'h20);
    clrWdtTwice <= 1'b0;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    reset = 1'b1;
    pulseReq = 1'b0;
    wdtEnable = 1'b0;
    clrWdtTwice = 1'b0;
    coreCmd = '0;
    apbReq = '0;
    portAWakePin = 8'hff;
    portAWakeEnable = 8'h00;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    t_power();
    t_halt_wake();
    t_pin_run();
    t_pin_halt();
    t_wdt_run();
    t_wdt_halt();
    t_wdt_pair();
    end_of_test();
  end
endmodule
